// ---- pkg/mcm_pkg.sv ----
package mcm_pkg;
    // Channel count and phase word width
    localparam int PHASE_W = 6;
    // Phase and preload value after reset: every switch off
    localparam logic [5:0] PHASE_RST = 6'h00;
    // Reset-state options for the output buffers
    localparam logic [1:0] RST_LVL_HIZ = 2'h0;
    localparam logic [1:0] RST_LVL_LOW = 2'h1;
    localparam logic [1:0] RST_LVL_HIGH = 2'h2;
    // Pin levels used by the reset-state options
    localparam logic [5:0] ALL_ONES = 6'h3f;
    localparam logic [5:0] ALL_ZEROS = 6'h00;
    // PWM group select codes: high-side or low-side group
    localparam logic SEL_HIGH = 1'b0;
    localparam logic SEL_LOW = 1'b1;
    // Main output enable after reset
    localparam logic MOE_RST = 1'b0;

    // Interval of the commutation step
    typedef enum logic [2:0] {
        ST_DEMAG = 3'h1,
        ST_BEMF = 3'h2,
        ST_AFTER_ZC = 3'h4
    } mcm_step_t;
    localparam mcm_step_t STEP_RST = ST_DEMAG;
endpackage

// ---- pkg/mcm_chan_if.sv ----
`timescale 1ns/1ps
interface mcm_chan_if;
    import mcm_pkg::*;
    logic comm;
    logic [5:0] phase;
    logic [5:0] next_phase;
    logic demag_sel;
    logic pwm_low_sel;
    mcm_step_t step;

    modport preload (output comm, phase, next_phase, demag_sel);
    modport steer (input comm, demag_sel, output pwm_low_sel, step);
    modport core (input comm, phase, next_phase, demag_sel, pwm_low_sel,
        step);
endinterface

// ---- rtl/mcm_phase_reg.sv ----
`timescale 1ns/1ps
module mcm_phase_reg
    import mcm_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_clk_en,
    input wire logic i_wr,
    input wire logic [5:0] i_wdata,
    input wire logic i_dac,
    input wire logic i_evt_comm,
    input wire logic i_demag_sel,
    mcm_chan_if.preload ch
);
    logic direct_wr;

    // A direct write is itself a commutation event
    assign direct_wr = i_wr & i_dac;
    assign ch.comm = i_evt_comm | direct_wr;

    // Preload register, writable at any time
    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            ch.next_phase <= PHASE_RST;
        else if (i_clk_en && i_wr)
            ch.next_phase <= i_wdata;
    end

    // Active phase loads only on a commutation event
    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            ch.phase <= PHASE_RST;
        else if (i_clk_en && ch.comm)
            ch.phase <= direct_wr ? i_wdata : ch.next_phase;
    end

    // Demag select latched at commutation, so a value written then counts
    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            ch.demag_sel <= SEL_HIGH;
        else if (i_clk_en && ch.comm)
            ch.demag_sel <= i_demag_sel;
    end

    a_preload_copy: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n)
        i_clk_en && i_evt_comm && !direct_wr
            |=> ch.phase == $past(ch.next_phase))
        else $error("phase not loaded from preload on commutation");

    a_direct_write: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n)
        i_clk_en && i_wr && i_dac |=> ch.phase == $past(i_wdata))
        else $error("direct write did not reach the phase");
endmodule

// ---- rtl/mcm_step_fsm.sv ----
`timescale 1ns/1ps
module mcm_step_fsm
    import mcm_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_clk_en,
    input wire logic i_dac,
    input wire logic i_sensor_mode,
    input wire logic i_evt_demag,
    input wire logic i_evt_zc,
    input wire logic i_bemf_sel,
    input wire logic i_after_zc_sel,
    mcm_chan_if.steer ch
);
    mcm_step_t next_step;

    // Step interval: C starts demag, D opens the window, Z ends it
    always_comb
    begin
        next_step = ch.step;
        if (ch.comm)
            next_step = ST_DEMAG;
        else
            unique case (ch.step)
                ST_DEMAG:
                    if (i_sensor_mode && i_evt_zc)
                        next_step = ST_AFTER_ZC;
                    else if (!i_sensor_mode && i_evt_demag)
                        next_step = ST_BEMF;
                ST_BEMF:
                    if (i_evt_zc)
                        next_step = ST_AFTER_ZC;
                ST_AFTER_ZC:
                    next_step = ST_AFTER_ZC;
                default:
                    next_step = STEP_RST;
            endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            ch.step <= STEP_RST;
        else if (i_clk_en)
            ch.step <= next_step;
    end

    // Group that receives PWM in the present interval
    always_comb
    begin
        if (i_dac)
            ch.pwm_low_sel = i_after_zc_sel;
        else
            unique case (ch.step)
                ST_DEMAG: ch.pwm_low_sel = ch.demag_sel;
                ST_BEMF: ch.pwm_low_sel = i_bemf_sel;
                ST_AFTER_ZC: ch.pwm_low_sel = i_after_zc_sel;
                default: ch.pwm_low_sel = SEL_HIGH;
            endcase
    end

    a_dac_select: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n)
        i_dac |-> ch.pwm_low_sel == i_after_zc_sel)
        else $error("direct access must use after-zc select");

    a_sensor_no_demag: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n)
        i_clk_en && i_sensor_mode && !ch.comm && ch.step == ST_DEMAG
            && !i_evt_zc |=> ch.step == ST_DEMAG)
        else $error("sensor mode left demag interval without Z");

    a_window_select: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n)
        !i_dac && ch.step == ST_BEMF |-> ch.pwm_low_sel == i_bemf_sel)
        else $error("window interval used wrong select");
endmodule

// ---- rtl/mcm_channel_manager.sv ----
// Operation
// - Preload is writable any time; it moves to the phase on commutation.
// - Phase bit 0 drives inverted polarity; phase 1 drives polarity with PWM.
// - In direct access a phase write is itself a commutation event.
// - In direct access the after-zero-crossing select alone picks PWM group.
// - Enable 0 gives reset state; direct access picks sequence or raw phase.
// - Reset-state level is high impedance, low or high by device option.
// - Group bit 0 puts an output in high side, 1 in low side.
// - PWM goes to upper or lower group by step state.
// - Output level depends on PWM, group and step, beside phase and polarity.
// - Demag select applies from C to D, latched at commutation.
// - Window select applies between D and Z events.
// - After-zero-crossing select applies between Z and next C.
// - Emergency low forces output buffers to reset state asynchronously.
// - Emergency also clears main output enable until software sets it.
// - Emergency raises an interrupt only when its mask bit is set.
// - Emergency forcing uses no clock and works with oscillator stopped.
// - Sensor mode has no demag event; selection changes only at C and Z.
`timescale 1ns/1ps
module mcm_channel_manager
    import mcm_pkg::*;
#(
    parameter logic [1:0] RESET_LEVEL = RST_LVL_HIZ
)
(
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_clk_en,
    input wire logic i_emergency_stop_n,
    input wire logic i_emergency_irq_mask,
    input wire logic i_main_output_enable_wr,
    input wire logic i_main_output_enable_wdata,
    input wire logic i_direct_access,
    input wire logic i_sensor_mode,
    input wire logic i_next_phase_wr,
    input wire logic [5:0] i_next_phase_bits,
    input wire logic [5:0] i_output_polarity_bits,
    input wire logic [5:0] i_group_assign,
    input wire logic i_demag_pwm_select,
    input wire logic i_bemf_window_pwm_select,
    input wire logic i_after_zc_pwm_select,
    input wire logic i_evt_comm,
    input wire logic i_evt_demag,
    input wire logic i_evt_zc,
    input wire logic i_pwm,
    output logic [5:0] o_motor_outputs,
    output logic [5:0] o_motor_outputs_oe,
    output logic o_main_output_enable,
    output logic [5:0] o_phase_state,
    output logic [5:0] o_next_phase_bits,
    output logic [2:0] o_step_state,
    output logic o_emergency_irq
);
    // Reset-state pin value and enable chosen by the device option
    localparam logic [5:0] RST_OUT =
        (RESET_LEVEL == RST_LVL_HIGH) ? ALL_ONES : ALL_ZEROS;
    localparam logic [5:0] RST_OE =
        (RESET_LEVEL == RST_LVL_HIZ) ? ALL_ZEROS : ALL_ONES;

    mcm_chan_if ch ();

    logic force_n;
    logic em_meta;
    logic em_sync;
    logic em_prev;
    logic [5:0] next_out;
    logic [5:0] sw_on;

    // Phase preload and active phase
    mcm_phase_reg u_phase (
        .i_sys_clk (i_sys_clk),
        .i_rst_n (i_rst_n),
        .i_clk_en (i_clk_en),
        .i_wr (i_next_phase_wr),
        .i_wdata (i_next_phase_bits),
        .i_dac (i_direct_access),
        .i_evt_comm (i_evt_comm),
        .i_demag_sel (i_demag_pwm_select),
        .ch (ch.preload)
    );

    // Step tracking and PWM group selection
    mcm_step_fsm u_step (
        .i_sys_clk (i_sys_clk),
        .i_rst_n (i_rst_n),
        .i_clk_en (i_clk_en),
        .i_dac (i_direct_access),
        .i_sensor_mode (i_sensor_mode),
        .i_evt_demag (i_evt_demag),
        .i_evt_zc (i_evt_zc),
        .i_bemf_sel (i_bemf_window_pwm_select),
        .i_after_zc_sel (i_after_zc_pwm_select),
        .ch (ch.steer)
    );

    // Emergency or reset drops the main enable, pin and buffer-enable flops without a clock edge
    assign force_n = i_rst_n & i_emergency_stop_n;

    // Phase and preload straight from their registers
    assign o_phase_state = ch.phase;
    assign o_next_phase_bits = ch.next_phase;
    assign o_step_state = ch.step;

    // Per-output shaping: group, PWM gating, polarity
    genvar gi;
    generate
        for (gi = 0; gi < PHASE_W; gi++)
        begin : g_out
            // PWM chops only outputs of the selected group
            assign sw_on[gi] = ch.phase[gi] &
                ((i_group_assign[gi] == ch.pwm_low_sel) ? i_pwm
                                                        : 1'b1);
            // Switch on drives polarity level, off drives its inverse
            assign next_out[gi] = sw_on[gi] ? i_output_polarity_bits[gi]
                : ~i_output_polarity_bits[gi];
        end
    endgenerate

    // Main output enable: software writes it, emergency clears it
    always_ff @(posedge i_sys_clk or negedge force_n)
    begin
        if (!force_n)
            o_main_output_enable <= MOE_RST;
        else if (i_clk_en && i_main_output_enable_wr)
            o_main_output_enable <= i_main_output_enable_wdata;
    end

    // Output pin levels; reset state while disabled or in emergency
    always_ff @(posedge i_sys_clk or negedge force_n)
    begin
        if (!force_n)
            o_motor_outputs <= RST_OUT;
        else if (i_clk_en)
        begin
            if (!o_main_output_enable)
                o_motor_outputs <= RST_OUT;
            else
                o_motor_outputs <= next_out;
        end
    end

    // Output buffer enables follow the same gating
    always_ff @(posedge i_sys_clk or negedge force_n)
    begin
        if (!force_n)
            o_motor_outputs_oe <= RST_OE;
        else if (i_clk_en)
        begin
            if (!o_main_output_enable)
                o_motor_outputs_oe <= RST_OE;
            else
                o_motor_outputs_oe <= ALL_ONES;
        end
    end

    // Emergency pin synchroniser for the interrupt path
    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            em_meta <= 1'b1;
            em_sync <= 1'b1;
            em_prev <= 1'b1;
        end
        else if (i_clk_en)
        begin
            em_meta <= i_emergency_stop_n;
            em_sync <= em_meta;
            em_prev <= em_sync;
        end
    end

    // One-cycle request on the falling edge when unmasked
    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_emergency_irq <= 1'b0;
        else if (i_clk_en)
            o_emergency_irq <= em_prev & ~em_sync
                & i_emergency_irq_mask;
    end

    a_emerg_forces_out: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n)
        !i_emergency_stop_n |-> o_motor_outputs == RST_OUT
            && o_motor_outputs_oe == RST_OE)
        else $error("outputs not in reset state during emergency");

    a_emerg_clears_moe: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n)
        $fell(i_emergency_stop_n) ##1 !i_main_output_enable_wr
            |-> !o_main_output_enable)
        else $error("emergency left main output enable set");

    a_moe_off_reset: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n)
        i_clk_en && !o_main_output_enable
            |=> o_motor_outputs == RST_OUT && o_motor_outputs_oe == RST_OE)
        else $error("disabled outputs not in reset state");

    a_irq_masked: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n)
        $rose(o_emergency_irq) |-> $past(i_emergency_irq_mask)
            && $past(i_clk_en))
        else $error("emergency interrupt raised while masked");

    a_irq_delay: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n)
        i_clk_en [*4] ##0 $past(i_emergency_stop_n, 3)
            && !$past(i_emergency_stop_n, 2) && i_emergency_irq_mask
            |=> o_emergency_irq)
        else $error("emergency interrupt not raised four edges later");

    a_off_level: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n)
        i_clk_en && o_main_output_enable && !ch.phase[0]
            ##1 i_emergency_stop_n
            |-> o_motor_outputs[0] == !$past(i_output_polarity_bits[0]))
        else $error("off output does not show inverse polarity");

    a_pwm_gating: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n)
        i_clk_en && o_main_output_enable && ch.phase[0]
            && (i_group_assign[0] == ch.pwm_low_sel) && !i_pwm
            ##1 i_emergency_stop_n
            |-> o_motor_outputs[0] == !$past(i_output_polarity_bits[0]))
        else $error("selected group not chopped by PWM low");

    a_other_group_on: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n)
        i_clk_en && o_main_output_enable && ch.phase[0]
            && (i_group_assign[0] != ch.pwm_low_sel)
            ##1 i_emergency_stop_n
            |-> o_motor_outputs[0] == $past(i_output_polarity_bits[0]))
        else $error("unselected group output not held on");

    // Checks on the enable, emergency and interrupt paths
    a_emerg_moe_low: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n)
        !i_emergency_stop_n |-> !o_main_output_enable)
        else $error("main output enable set while emergency is low");

    a_moe_write: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n)
        i_clk_en && i_emergency_stop_n && i_main_output_enable_wr
            ##1 i_emergency_stop_n
            |-> o_main_output_enable == $past(i_main_output_enable_wdata))
        else $error("main output enable write not taken");

    a_oe_driving: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n)
        i_clk_en && o_main_output_enable ##1 i_emergency_stop_n
            |-> o_motor_outputs_oe == ALL_ONES)
        else $error("enabled outputs not driving");

    a_irq_pulse: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n)
        i_clk_en && o_emergency_irq |=> !o_emergency_irq)
        else $error("emergency interrupt longer than one cycle");

    // Checks on step tracking and frozen state
    a_freeze_state: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n)
        !i_clk_en |=> $stable(ch.phase) && $stable(ch.next_phase)
            && $stable(ch.step))
        else $error("state moved while clock enable was low");

    a_step_onehot: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n)
        $onehot(ch.step))
        else $error("step state is not one-hot");

    a_comm_restart: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n)
        i_clk_en && ch.comm |=> ch.step == ST_DEMAG
            && ch.demag_sel == $past(i_demag_pwm_select))
        else $error("commutation did not restart demag interval");

    a_demag_step: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n)
        i_clk_en && !ch.comm && !i_sensor_mode && i_evt_demag
            && ch.step == ST_DEMAG |=> ch.step == ST_BEMF)
        else $error("demag end did not open the window interval");

    a_sensor_zc: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n)
        i_clk_en && !ch.comm && i_sensor_mode && i_evt_zc
            && ch.step == ST_DEMAG |=> ch.step == ST_AFTER_ZC)
        else $error("sensor mode Z did not end the first interval");

    a_zc_step: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n)
        i_clk_en && !ch.comm && i_evt_zc && ch.step == ST_BEMF
            |=> ch.step == ST_AFTER_ZC)
        else $error("zero crossing did not end the window interval");

    // Checks on PWM group routing
    a_after_zc_sel: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n)
        !i_direct_access && ch.step == ST_AFTER_ZC
            |-> ch.pwm_low_sel == i_after_zc_pwm_select)
        else $error("after-zc interval used wrong select");

    a_pwm_pass: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n)
        i_clk_en && o_main_output_enable && ch.phase[0]
            && (i_group_assign[0] == ch.pwm_low_sel) && i_pwm
            ##1 i_emergency_stop_n
            |-> o_motor_outputs[0] == $past(i_output_polarity_bits[0]))
        else $error("selected group output not on while PWM high");
endmodule

// ---- tb/mcm_driver_model.sv ----
`timescale 1ns/1ps
module mcm_driver_model
    import mcm_pkg::*;
(
    input wire logic [5:0] i_motor_outputs,
    input wire logic [5:0] i_motor_outputs_oe,
    input wire logic [5:0] i_output_polarity_bits,
    output logic [5:0] o_switch_on
);
    // Gate lines fall to the pull-down level once released
    logic [5:0] gate_line;
    assign gate_line = i_motor_outputs & i_motor_outputs_oe;
    // Switch conducts when the driven gate line matches its polarity level
    assign o_switch_on = i_motor_outputs_oe
        & ~(gate_line ^ i_output_polarity_bits);
endmodule

// ---- tb/tb_motor_channel_manager.sv ----
`timescale 1ns/1ps
module tb_motor_channel_manager;
    import mcm_pkg::*;
    logic i_sys_clk = 1'b0;
    logic clk_run = 1'b1;
    logic i_rst_n, i_clk_en, i_emergency_stop_n, i_emergency_irq_mask;
    logic i_main_output_enable_wr, i_main_output_enable_wdata;
    logic i_direct_access, i_sensor_mode, i_next_phase_wr, i_pwm;
    logic i_demag_pwm_select, i_bemf_window_pwm_select;
    logic i_after_zc_pwm_select, i_evt_comm, i_evt_demag, i_evt_zc;
    logic [5:0] i_next_phase_bits, i_output_polarity_bits, i_group_assign;
    logic [5:0] o_motor_outputs, o_motor_outputs_oe, o_phase_state;
    logic [5:0] o_next_phase_bits, o_switch_on;
    logic [2:0] o_step_state;
    logic o_main_output_enable, o_emergency_irq;
    int n_errors = 0;
    int n_tests = 0;

    // Clock, held still while the oscillator is meant to be stopped
    always #50 i_sys_clk = clk_run ? ~i_sys_clk : i_sys_clk;

    mcm_channel_manager #(.RESET_LEVEL(RST_LVL_HIZ)) dut (.*);
    mcm_driver_model drv (
        .i_motor_outputs(o_motor_outputs),
        .i_motor_outputs_oe(o_motor_outputs_oe),
        .i_output_polarity_bits(i_output_polarity_bits),
        .o_switch_on(o_switch_on)
    );

    // Comparison with mismatch report
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic close_out;
        $display("errors=%0d tests=%0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Waits edges, then steps past them so outputs are settled
    task automatic wait_edges(input int n);
        repeat (n) @(posedge i_sys_clk);
        #1;
    endtask

    // Pin levels worked out from phase, group, polarity and PWM
    function automatic logic [5:0] exp_pins(input logic [5:0] ph,
        input logic sel, input logic pwm);
        logic [5:0] on;
        on = ph & ~(~(i_group_assign ^ {6{sel}}) & {6{~pwm}});
        return ~(on ^ i_output_polarity_bits);
    endfunction

    task automatic moe_write(input logic v);
        @(posedge i_sys_clk);
        i_main_output_enable_wr <= 1'b1;
        i_main_output_enable_wdata <= v;
        @(posedge i_sys_clk);
        i_main_output_enable_wr <= 1'b0;
    endtask

    task automatic phase_write(input logic [5:0] v);
        @(posedge i_sys_clk);
        i_next_phase_wr <= 1'b1;
        i_next_phase_bits <= v;
        @(posedge i_sys_clk);
        i_next_phase_wr <= 1'b0;
    endtask

    // One-cycle event pulse: 0 commutation, 1 demag end, 2 zero crossing
    task automatic fire(input int which);
        @(posedge i_sys_clk);
        i_evt_comm <= (which == 0);
        i_evt_demag <= (which == 1);
        i_evt_zc <= (which == 2);
        @(posedge i_sys_clk);
        {i_evt_comm, i_evt_demag, i_evt_zc} <= 3'h0;
    endtask

    task automatic t_reset;
        wait_edges(1);
        chk(o_phase_state, PHASE_RST);
        chk(o_main_output_enable, MOE_RST);
        chk(o_motor_outputs_oe, ALL_ZEROS);
        chk(o_step_state, STEP_RST);
    endtask

    task automatic t_sequence;
        moe_write(1'b1);
        phase_write(6'h0f);
        wait_edges(2);
        chk(o_next_phase_bits, 8'h0f);
        chk(o_phase_state, PHASE_RST);
        chk(o_motor_outputs, exp_pins(6'h00, 1'b0, 1'b0));
        i_demag_pwm_select <= 1'b1;
        fire(0);
        i_demag_pwm_select <= 1'b0;
        wait_edges(3);
        chk(o_phase_state, 8'h0f);
        chk(o_motor_outputs_oe, ALL_ONES);
        chk(o_motor_outputs, exp_pins(6'h0f, 1'b1, 1'b0));
        i_pwm <= 1'b1;
        wait_edges(2);
        chk(o_motor_outputs, exp_pins(6'h0f, 1'b1, 1'b1));
        chk(o_switch_on, 8'h0f);
        i_pwm <= 1'b0;
        fire(2);
        wait_edges(2);
        chk(o_step_state, 8'h01);
        fire(1);
        wait_edges(3);
        chk(o_step_state, 8'h02);
        chk(o_motor_outputs, exp_pins(6'h0f, 1'b0, 1'b0));
        i_pwm <= 1'b1;
        wait_edges(2);
        chk(o_motor_outputs, exp_pins(6'h0f, 1'b0, 1'b1));
        i_pwm <= 1'b0;
        i_after_zc_pwm_select <= 1'b1;
        fire(2);
        wait_edges(3);
        chk(o_step_state, 8'h04);
        chk(o_motor_outputs, exp_pins(6'h0f, 1'b1, 1'b0));
    endtask

    task automatic t_direct;
        i_direct_access <= 1'b1;
        i_after_zc_pwm_select <= 1'b0;
        i_bemf_window_pwm_select <= 1'b1;
        i_demag_pwm_select <= 1'b1;
        phase_write(6'h2a);
        wait_edges(0);
        chk(o_phase_state, 8'h2a);
        wait_edges(3);
        chk(o_motor_outputs, exp_pins(6'h2a, SEL_HIGH, 1'b0));
        i_direct_access <= 1'b0;
    endtask

    task automatic t_sensor;
        i_sensor_mode <= 1'b1;
        fire(0);
        fire(1);
        wait_edges(2);
        chk(o_step_state, 8'h01);
        fire(2);
        wait_edges(2);
        chk(o_step_state, 8'h04);
        i_sensor_mode <= 1'b0;
    endtask

    // Clock enable low: strobes and events are ignored
    task automatic t_freeze;
        @(posedge i_sys_clk);
        i_clk_en <= 1'b0;
        phase_write(6'h15);
        fire(0);
        wait_edges(1);
        chk(o_next_phase_bits, 8'h2a);
        chk(o_phase_state, 8'h2a);
        chk(o_step_state, 8'h04);
        i_clk_en <= 1'b1;
    endtask

    // Emergency with the clock running, then with it stopped
    task automatic t_emergency;
        logic seen;
        i_emergency_irq_mask <= 1'b1;
        @(posedge i_sys_clk);
        #30 i_emergency_stop_n = 1'b0;
        #1;
        chk(o_motor_outputs_oe, ALL_ZEROS);
        chk(o_main_output_enable, 8'h00);
        seen = 1'b0;
        repeat (6)
        begin
            wait_edges(1);
            if (o_emergency_irq === 1'b1)
                seen = 1'b1;
        end
        chk(seen, 8'h01);
        @(posedge i_sys_clk);
        i_emergency_stop_n <= 1'b1;
        wait_edges(4);
        chk(o_main_output_enable, 8'h00);
        moe_write(1'b1);
        i_emergency_irq_mask <= 1'b0;
        wait_edges(3);
        chk(o_motor_outputs_oe, ALL_ONES);
        #10 clk_run = 1'b0;
        #300 i_emergency_stop_n = 1'b0;
        #100;
        chk(o_motor_outputs_oe, ALL_ZEROS);
        chk(o_main_output_enable, 8'h00);
        clk_run = 1'b1;
        seen = 1'b0;
        repeat (6)
        begin
            wait_edges(1);
            if (o_emergency_irq !== 1'b0)
                seen = 1'b1;
        end
        chk(seen, 8'h00);
    endtask

    // Time-zero values, reset, then the scenarios
    initial
    begin
        {i_rst_n, i_main_output_enable_wr, i_main_output_enable_wdata} = 3'h0;
        {i_direct_access, i_sensor_mode, i_next_phase_wr, i_pwm} = 4'h0;
        {i_evt_comm, i_evt_demag, i_evt_zc, i_emergency_irq_mask} = 4'h0;
        {i_demag_pwm_select, i_bemf_window_pwm_select} = 2'h0;
        i_after_zc_pwm_select = 1'b0;
        {i_clk_en, i_emergency_stop_n} = 2'h3;
        i_next_phase_bits = 6'h00;
        i_output_polarity_bits = 6'h33;
        i_group_assign = 6'h2a;
        repeat (3) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        t_reset();
        t_sequence();
        t_direct();
        t_sensor();
        t_freeze();
        t_emergency();
        close_out();
    end

    // Watchdog against a hang
    initial
    begin
        #500000;
        n_errors++;
        close_out();
    end
endmodule
